/* ebhb_host_bus.v */
// Eight-bit multiplexed host bus master port.
// Assumes an external address latch and up to two peripherals.
// Functional notes
// - Host bus active when main mode is 0x2
// - Muxed variant when host bus mode is 0x0
// - Low address then data on shared lines
// - Pulse latch strobe in address phase
// - Only matching read or write strobe asserts
// - Provide up to two chip selects
// - Chip-select field picks strobe and selects
// - 0x0 latch strobe only; 0x1 one select
// - 0x2 two selects; 0x3 strobe plus two
`timescale 1ns/100ps
`include "ebhb_defines.vh"
module ebhb_host_bus #(
  parameter ADDR_W      = 28,
  parameter PHASE_CYCLES = `EBHB_PHASE_CYCLES
) (
  // Clock, reset, enable
  input  wire              I_CORE_CLK,
  input  wire              I_RST,
  input  wire              I_CE,
  // Configuration
  input  wire [1:0]        I_MAIN_MODE,
  input  wire [1:0]        I_HB_MODE,
  input  wire [1:0]        I_CHIP_SELECT_CONFIG,
  // Request side
  input  wire              I_REQ_VALID,
  input  wire              I_REQ_WRITE,
  input  wire [ADDR_W-1:0] I_REQ_ADDR,
  input  wire [7:0]        I_REQ_WDATA,
  output wire              O_REQ_READY,
  output reg               O_RSP_VALID,
  output reg  [7:0]        O_RSP_RDATA,
  // Shared address/data lines
  input  wire [7:0]        I_AD,
  output reg  [7:0]        O_AD,
  output reg               O_AD_OE,
  // Dedicated upper address
  output reg  [ADDR_W-9:0] O_ADDR_HI,
  // Strobes; latch strobe active high, others active low
  output reg               O_ALE,
  output reg               O_RD_N,
  output reg               O_WR_N,
  output reg  [1:0]        O_CS_N
);
  // ****************************************
  // State encoding
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  reg [3:0]        state_ff;
  reg [3:0]        nxt_state;
  reg [3:0]        cnt_ff;
  reg              write_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [7:0]        wdata_ff;
  wire [7:0]       ad_sync;

  // Pin input crosses four flops before use
  ebhb_sync3 #(
    .WIDTH (8)
  ) u_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_async (I_AD),
    .o_sync  (ad_sync)
  );

  wire port_on = (I_MAIN_MODE == `EBHB_MAIN_MODE_HB8) && (I_HB_MODE == `EBHB_HB_MODE_MUXED);

  function use_ale;
    input [1:0] cfg;
    begin
      use_ale = (cfg == `EBHB_CHIP_SELECT_CONFIG_ALE) || (cfg == `EBHB_CHIP_SELECT_CONFIG_ALE_TWO_CS);
    end
  endfunction

  function [1:0] cs_count;
    input [1:0] cfg;
    begin
      case (cfg)
        `EBHB_CHIP_SELECT_CONFIG_ONE_CS:     cs_count = 2'h1;
        `EBHB_CHIP_SELECT_CONFIG_TWO_CS:     cs_count = 2'h2;
        `EBHB_CHIP_SELECT_CONFIG_ALE_TWO_CS: cs_count = 2'h2;
        default:                cs_count = 2'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Phase timing
  // ****************************************
  // A read holds its strobe until the line has crossed the synchroniser and
  // its agreement stage; a shorter phase would hand back a stale byte.
  localparam RD_CYCLES = (PHASE_CYCLES > `EBHB_SYNC_SETTLE) ? PHASE_CYCLES : `EBHB_SYNC_SETTLE;

  wire last_cnt = (cnt_ff == PHASE_CYCLES[3:0] - 4'h1);
  wire last_rd  = (cnt_ff == RD_CYCLES[3:0] - 4'h1);
  // Writes need no settling, so they keep the plain phase length
  wire data_end = write_ff ? last_cnt : last_rd;
  assign O_REQ_READY = (state_ff == ST_IDLE) && port_on;

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (I_REQ_VALID && O_REQ_READY) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (last_cnt) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (data_end) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 4'h0;
      write_ff    <= 1'b0;
      addr_ff     <= {ADDR_W{1'b0}};
      wdata_ff    <= 8'h00;
      O_RSP_VALID <= 1'b0;
      O_RSP_RDATA <= 8'h00;
    end else if (I_CE) begin
      state_ff    <= nxt_state;
      O_RSP_VALID <= 1'b0;
      if (state_ff != nxt_state) begin
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (state_ff == ST_IDLE && I_REQ_VALID && O_REQ_READY) begin
        write_ff <= I_REQ_WRITE;
        addr_ff  <= I_REQ_ADDR;
        wdata_ff <= I_REQ_WDATA;
      end
      // Sample read data at the end of the data phase
      if (state_ff == ST_DATA && data_end) begin
        O_RSP_VALID <= 1'b1;
        if (!write_ff) begin
          O_RSP_RDATA <= ad_sync;
        end
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_AD      <= 8'h00;
      O_AD_OE   <= 1'b0;
      O_ADDR_HI <= {(ADDR_W-8){1'b0}};
      O_ALE     <= 1'b0;
      O_RD_N    <= 1'b1;
      O_WR_N    <= 1'b1;
      O_CS_N    <= 2'h3;
    end else if (I_CE) begin
      O_ALE  <= 1'b0;
      O_RD_N <= 1'b1;
      O_WR_N <= 1'b1;
      case (nxt_state)
        ST_ADDR: begin
          O_AD      <= (state_ff == ST_IDLE) ? I_REQ_ADDR[7:0] : addr_ff[7:0];
          O_AD_OE   <= 1'b1;
          O_ADDR_HI <= (state_ff == ST_IDLE) ? I_REQ_ADDR[ADDR_W-1:8] : addr_ff[ADDR_W-1:8];
          O_ALE     <= use_ale(I_CHIP_SELECT_CONFIG);
          if (cs_count(I_CHIP_SELECT_CONFIG) == 2'h1) begin
            O_CS_N <= 2'h2;
          end else if (cs_count(I_CHIP_SELECT_CONFIG) == 2'h2) begin
            O_CS_N <= ((state_ff == ST_IDLE) ? I_REQ_ADDR[`EBHB_CS_SEL_BIT] : addr_ff[`EBHB_CS_SEL_BIT])
                      ? 2'h1 : 2'h2;
          end else begin
            O_CS_N <= 2'h3;
          end
        end
        ST_DATA: begin
          O_AD    <= write_ff ? wdata_ff : 8'h00;
          O_AD_OE <= write_ff;
          O_RD_N  <= write_ff;
          O_WR_N  <= ~write_ff;
        end
        default: begin
          O_AD_OE <= 1'b0;
          O_CS_N  <= 2'h3;
        end
      endcase
    end
  end
endmodule

/* ebhb_defines.vh */
// Constants for the eight-bit multiplexed host bus port.
// Assumes inclusion by bare name; definitions only.
`ifndef EBHB_DEFINES_VH
`define EBHB_DEFINES_VH
// ****************************************
// Mode encodings
// ****************************************
`define EBHB_MAIN_MODE_HB8     2'h2
`define EBHB_HB_MODE_MUXED     2'h0
`define EBHB_CHIP_SELECT_CONFIG_ALE         2'h0
`define EBHB_CHIP_SELECT_CONFIG_ONE_CS      2'h1
`define EBHB_CHIP_SELECT_CONFIG_TWO_CS      2'h2
`define EBHB_CHIP_SELECT_CONFIG_ALE_TWO_CS  2'h3
// ****************************************
// Field positions
// ****************************************
`define EBHB_LOW_ADDR_W        8
`define EBHB_CS_SEL_BIT        27
// ****************************************
// Reset values and timing counts
// ****************************************
`define EBHB_MAIN_MODE_RST     2'h0
`define EBHB_HB_MODE_RST       2'h0
`define EBHB_CHIP_SELECT_CONFIG_RST         2'h0
`define EBHB_PHASE_CYCLES      4'h2
// Read strobe cycles before the synchronised line may be sampled
`define EBHB_SYNC_SETTLE       4'h5
`endif

/* ebhb_sync3.v */
// Three-stage synchroniser for a pin input.
// Assumes one clock; output changes when stages two and three agree.
`timescale 1ns/100ps
module ebhb_sync3 #(
  parameter WIDTH = 8
) (
  // Clock and control
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_ce,
  // Data
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  always @(posedge i_clk) begin
    if (i_rst) begin
      s1_ff  <= {WIDTH{1'b0}};
      s2_ff  <= {WIDTH{1'b0}};
      s3_ff  <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_sync <= s3_ff;
      end
    end
  end
endmodule

/* ebhb_props.sv */
// Pin assertions for the host bus port.
// Assumes bind into ebhb_host_bus, one clock.
`timescale 1ns/100ps
`include "ebhb_defines.vh"
module ebhb_props #(
  parameter ADDR_W       = 28,
  parameter PHASE_CYCLES = 2
) (
  input wire              I_CORE_CLK,
  input wire              I_RST,
  input wire [1:0]        I_MAIN_MODE,
  input wire [1:0]        I_HB_MODE,
  input wire [1:0]        I_CHIP_SELECT_CONFIG,
  input wire              I_REQ_VALID,
  input wire              I_REQ_WRITE,
  input wire [ADDR_W-1:0] I_REQ_ADDR,
  input wire              O_REQ_READY,
  input wire              O_RSP_VALID,
  input wire [7:0]        O_AD,
  input wire              O_ALE,
  input wire              O_RD_N,
  input wire              O_WR_N,
  input wire [1:0]        O_CS_N
);
  localparam int DP = PHASE_CYCLES + 1;
  localparam int RP = 2 * PHASE_CYCLES + 1;
  localparam int SETTLE = `EBHB_SYNC_SETTLE;
  localparam int RRP = PHASE_CYCLES + ((PHASE_CYCLES > SETTLE) ? PHASE_CYCLES : SETTLE) + 1;
  wire       tk = I_REQ_VALID && O_REQ_READY;
  wire [7:0] ab = I_REQ_ADDR[7:0];
  wire [1:0] cf = I_CHIP_SELECT_CONFIG;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  a_ready_mode: assert property (O_REQ_READY |-> I_MAIN_MODE == 2'h2 && I_HB_MODE == 2'h0)
    else $error("ready out of mode");
  a_rsp_time: assert property (tk && I_REQ_WRITE |-> ##RP O_RSP_VALID)
    else $error("late write response");
  a_rsp_read: assert property (tk && !I_REQ_WRITE |-> ##RRP O_RSP_VALID)
    else $error("late read response");
  a_addr_phase: assert property (tk |=> O_AD == $past(ab))
    else $error("bad address byte");
  a_rd_strobe: assert property (tk && !I_REQ_WRITE |-> ##DP !O_RD_N && O_WR_N)
    else $error("bad read strobe");
  a_ale_pulse: assert property (tk && cf[0] == cf[1] |=> O_ALE)
    else $error("no latch strobe");
  a_ale_cfg: assert property (O_ALE |-> cf == 2'h0 || cf == 2'h3)
    else $error("latch strobe not enabled");
  a_cs_one: assert property (cf == 2'h1 |-> O_CS_N[1])
    else $error("second select in one-select mode");
  a_cs_excl: assert property (O_CS_N != 2'h0)
    else $error("both selects low");
  c_wr: cover property (tk && I_REQ_WRITE);
  c_rd: cover property (tk && !I_REQ_WRITE);
  c_off: cover property (!O_REQ_READY && I_HB_MODE != 2'h0);
endmodule

/* ebhb_periph.sv */
// Model of the address latch and one byte-wide peripheral.
// Assumes the port's pin outputs; returns the shared line level.
`timescale 1ns/100ps
module ebhb_periph (
  input  wire       i_clk,
  input  wire [7:0] i_ad,
  input  wire       i_oe,
  input  wire       i_ale,
  input  wire       i_ale_wired,
  input  wire [1:0] i_cs_n,
  input  wire       i_rd_n,
  input  wire       i_wr_n,
  output wire [7:0] o_ad
);
  reg [7:0] mem [0:255];
  reg [7:0] addr_ff;
  reg [7:0] last_ff = 8'h00;
  // with the latch strobe wired, only that strobe captures the address
  wire take_addr = i_ale_wired ? i_ale : (i_oe && i_rd_n && i_wr_n && (i_cs_n != 2'h3));
  always @(posedge i_clk) begin
    if (take_addr)
      addr_ff <= i_ad;
    if (!i_wr_n)
      mem[addr_ff] <= i_ad;
    last_ff <= o_ad;
  end
  // Released line shows inverse of last value, no pull
  assign o_ad = i_oe ? i_ad : (!i_rd_n ? mem[addr_ff] : ~last_ff);
endmodule

/* test_eight_bit_muxed_host_bus.sv */
// Bench for the host bus port.
// Assumes ebhb_props and ebhb_periph compiled first.
`timescale 1ns/100ps
module test_eight_bit_muxed_host_bus;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         vld = 1'b0;
  reg         we = 1'b0;
  reg  [1:0]  mm = 2'h2;
  reg  [1:0]  hm = 2'h0;
  reg  [1:0]  cc = 2'h0;
  reg  [27:0] adr = 28'h000_0000;
  reg  [7:0]  wd = 8'h00;
  reg  [1:0]  cs_s;
  reg         ale_s;
  wire [7:0]  ad_o, ad_i, rdat;
  wire [19:0] ahi;
  wire        rdy, rv, oe, ale, rdn, wrn;
  wire [1:0]  csn;
  integer     n_fail = 0;
  integer     check_count = 0;
  always #4 clk = ~clk;
  ebhb_host_bus #(.PHASE_CYCLES(4)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1),
    .I_MAIN_MODE(mm), .I_HB_MODE(hm), .I_CHIP_SELECT_CONFIG(cc), .I_REQ_VALID(vld),
    .I_REQ_WRITE(we), .I_REQ_ADDR(adr), .I_REQ_WDATA(wd), .O_REQ_READY(rdy), .O_RSP_VALID(rv),
    .O_RSP_RDATA(rdat), .I_AD(ad_i), .O_AD(ad_o), .O_AD_OE(oe), .O_ADDR_HI(ahi), .O_ALE(ale),
    .O_RD_N(rdn), .O_WR_N(wrn), .O_CS_N(csn));
  ebhb_periph far (.i_clk(clk), .i_ad(ad_o), .i_oe(oe), .i_ale(ale), .i_ale_wired(cc == 2'h0 || cc == 2'h3),
    .i_cs_n(csn), .i_rd_n(rdn), .i_wr_n(wrn), .o_ad(ad_i));
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      if (n_fail == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // One transfer; bounded waits on ready and response
  task xfer(input w, input [27:0] a, input [7:0] d);
    integer k;
    begin
      k = 0;
      @(posedge clk);
      vld <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(negedge clk);
      while (rdy !== 1'b1 && k < 50) begin
        @(negedge clk);
        k = k + 1;
      end
      @(posedge clk);
      vld <= 1'b0;
      @(negedge clk);
      cs_s = csn;
      ale_s = ale;
      chk(ahi, a[27:8]);
      @(negedge clk);
      while (rv !== 1'b1 && k < 50) begin
        @(negedge clk);
        k = k + 1;
      end
      chk(k < 50, 1);
    end
  endtask
  task t_modes;
    begin
      chk({csn, rdn, wrn, oe}, 5'h1e);
      @(posedge clk);
      mm <= 2'h0;
      @(negedge clk);
      chk(rdy, 0);
      @(posedge clk);
      mm <= 2'h2;
      hm <= 2'h1;
      @(negedge clk);
      chk(rdy, 0);
      @(posedge clk);
      hm <= 2'h0;
    end
  endtask
  task t_cfg(input [1:0] c);
    reg [27:0] a;
    begin
      a = {c[0], 19'h1_2345, 6'h00, c};
      @(posedge clk);
      cc <= c;
      xfer(1'b1, a, 8'ha5 ^ {6'h00, c});
      chk(cs_s, c == 2'h0 ? 2'h3 : c == 2'h3 ? 2'h1 : 2'h2);
      chk(ale_s, c == 2'h0 || c == 2'h3);
      xfer(1'b0, a, 8'h00);
      chk(rdat, 8'ha5 ^ {6'h00, c});
    end
  endtask
  initial begin
    integer i;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_modes;
    for (i = 0; i < 4; i = i + 1)
      t_cfg(i[1:0]);
    print_verdict;
  end
  initial begin
    #40000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule
bind ebhb_host_bus ebhb_props #(.ADDR_W(ADDR_W), .PHASE_CYCLES(PHASE_CYCLES)) u_props (.*);
